// >>> master_clock_prescaler.v
// What this block does
// - Clock mode field picks bypass or PLL generation
// - CPU clock is master clock or half of it
// - CPU core and bus controller use CPU clock
// - Peripheral clock always equals CPU clock frequency
// - Mode 0x divides oscillator by both prescalers
// - Bypass with both prescalers zero: master follows oscillator directly
// - Input prescale up to 3, output up to 14
// - Mode 11 multiplies, divides, and adjusts smoothly
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ps
`include "master_clock_prescaler_defs.vh"

module master_clock_prescaler (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        oscillator_clock,
    output reg         master_clock,
    output reg         master_clock_tick,
    output reg         cpu_clock,
    output reg         cpu_clock_tick,
    output reg         cpu_core_clk_en,
    output reg         external_bus_ctrl_clk_en,
    output reg         peripheral_clock,
    output reg         peripheral_clock_tick
);

    // Maps a bus address onto a register index
    function [1:0] reg_index;
        input [11:0] addr;
        begin
            case (addr)
                `OFS_CLOCK_GEN_CONFIG: reg_index = `IDX_CLOCK_GEN_CONFIG;
                `OFS_SYSTEM_CONFIG_1:  reg_index = `IDX_SYSTEM_CONFIG_1;
                `OFS_CLOCK_STATUS:     reg_index = `IDX_CLOCK_STATUS;
                default:               reg_index = `IDX_NONE;
            endcase
        end
    endfunction

    // Configuration fields
    reg  [3:0]  output_prescale_q;    // Output prescaler factor minus one
    reg  [1:0]  input_prescale_q;     // Input prescaler factor minus one
    reg  [1:0]  clock_mode_select_q;  // Generation mechanism
    reg  [4:0]  vco_multiplier_q;     // Multiplier minus one
    reg         cpu_clock_halve_q;    // CPU clock at half master rate

    // Bus decode
    wire [1:0]  idx;                  // Index of the addressed register
    wire        wr_access;            // Write completes this edge
    wire        cfg_wr;               // Write to clock_gen_config
    wire        sys_wr;               // Write to system_config_1

    // Oscillator sampling
    reg         osc_q;                // Oscillator level one cycle ago
    wire        osc_rise;             // Rising oscillator edge seen

    // Mode decode
    wire        pll_on;               // PLL mode active
    wire        direct;               // Master clock follows oscillator

    // Prescaler chain
    wire        in_tick;              // Input prescaler output event
    wire        out_src;              // Event fed to output prescaler
    wire        mc_tick;              // Master clock period start

    // Reference period tracking
    reg  [15:0] per_cnt_q;            // Cycles since last reference tick
    reg  [15:0] per_est_q;            // Smoothed reference period
    reg         ref_seen_q;           // A reference tick has been seen
    reg         est_valid_q;          // Period estimate is usable
    reg         locked_q;             // Estimate matches last measurement
    wire [15:0] per_meas;             // Period just measured

    // Synthesised oscillator
    reg  [15:0] acc_q;                // Phase accumulator
    reg  [15:0] acc_d;
    wire [15:0] acc_sum;              // Accumulator plus one step
    wire [5:0]  step;                 // Multiplier factor
    wire        vco_tick;             // Synthesised clock event

    // CPU divider
    reg         phase_q;              // Alternates on each master tick
    wire        cpu_tick;             // CPU clock period start
    reg         cpu_level_d;          // Next CPU clock level
    reg         mc_level_d;           // Next master clock level

    // Bus access decode; zero wait states
    assign idx       = reg_index(paddr);
    assign pready    = psel & penable;
    assign pslverr   = pready & (idx == `IDX_NONE);
    assign wr_access = pready & pwrite;
    assign cfg_wr    = wr_access & (idx == `IDX_CLOCK_GEN_CONFIG);
    assign sys_wr    = wr_access & (idx == `IDX_SYSTEM_CONFIG_1);

    // Configuration registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_prescale_q   <= `OPS_RST;
            input_prescale_q    <= `IPS_RST;
            clock_mode_select_q <= `MODE_RST;
            vco_multiplier_q    <= `MUL_RST;
            cpu_clock_halve_q   <= `HALVE_RST;
        end else begin
            if (cfg_wr) begin
                // Choice of mechanism is software controlled
                clock_mode_select_q <= pwdata[`MODE_MSB:`MODE_LSB];
                input_prescale_q    <= pwdata[`IPS_MSB:`IPS_LSB];
                vco_multiplier_q    <= pwdata[`MUL_MSB:`MUL_LSB];
                // Reserved factor is refused, old value kept
                if (pwdata[`OPS_MSB:`OPS_LSB] != `OPS_RESERVED) begin
                    output_prescale_q <= pwdata[`OPS_MSB:`OPS_LSB];
                end
            end
            if (sys_wr) begin
                // Halving select for the CPU clock
                cpu_clock_halve_q <= pwdata[`HALVE_BIT];
            end
        end
    end

    // Read data captured in the setup cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= `RDATA_ZERO;
        end else if (psel & ~penable & ~pwrite) begin
            prdata <= `RDATA_ZERO;
            case (idx)
                `IDX_CLOCK_GEN_CONFIG: begin
                    prdata[`OPS_MSB:`OPS_LSB]   <= output_prescale_q;
                    prdata[`IPS_MSB:`IPS_LSB]   <= input_prescale_q;
                    prdata[`MODE_MSB:`MODE_LSB] <= clock_mode_select_q;
                    prdata[`MUL_MSB:`MUL_LSB]   <= vco_multiplier_q;
                end
                `IDX_SYSTEM_CONFIG_1: begin
                    prdata[`HALVE_BIT] <= cpu_clock_halve_q;
                end
                `IDX_CLOCK_STATUS: begin
                    prdata[`ST_PLL_BIT]   <= pll_on;
                    prdata[`ST_LOCK_BIT]  <= locked_q;
                    prdata[`ST_HALVE_BIT] <= cpu_clock_halve_q;
                    prdata[`ST_PER_LSB+15:`ST_PER_LSB] <= per_est_q;
                end
                default: begin
                    // Unmapped: reads zero, error flagged
                    prdata <= `RDATA_ZERO;
                end
            endcase
        end
    end

    // Oscillator edge detection
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_q <= 1'b0;
        end else begin
            osc_q <= oscillator_clock;
        end
    end
    assign osc_rise = oscillator_clock & ~osc_q;

    // Upper mode bit clear means bypass both set means PLL
    assign pll_on = (clock_mode_select_q == `MODE_PLL);
    assign direct = ~pll_on & (input_prescale_q == `IPS_RST)
                    & (output_prescale_q == `DIV_ZERO);

    // Input prescaler counts oscillator edges
    tick_divider u_input_prescaler (
        .pclk     (pclk),
        .presetn  (presetn),
        .clear    (cfg_wr),
        .tick_in  (osc_rise),
        .div      ({2'b00, input_prescale_q}),
        .tick_out (in_tick)
    );

    // Output prescaler takes bypass or synthesised events
    assign out_src = pll_on ? vco_tick : in_tick;

    tick_divider u_output_prescaler (
        .pclk     (pclk),
        .presetn  (presetn),
        .clear    (cfg_wr),
        .tick_in  (out_src),
        .div      (output_prescale_q),
        .tick_out (mc_tick)
    );

    // Reference period measurement and smoothing
    assign per_meas = (per_cnt_q == `PER_MAX) ? `PER_MAX
                                               : per_cnt_q + `PER_ONE;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            per_cnt_q   <= `PER_ZERO;
            per_est_q   <= `PER_ZERO;
            ref_seen_q  <= 1'b0;
            est_valid_q <= 1'b0;
            locked_q    <= 1'b0;
        end else if (!pll_on || cfg_wr) begin
            // Tracking restarts whenever PLL mode is left or reprogrammed
            per_cnt_q   <= `PER_ZERO;
            ref_seen_q  <= 1'b0;
            est_valid_q <= 1'b0;
            locked_q    <= 1'b0;
        end else if (in_tick) begin
            per_cnt_q  <= `PER_ZERO;
            ref_seen_q <= 1'b1;
            if (ref_seen_q && !est_valid_q) begin
                // First full period loads the estimate
                per_est_q   <= per_meas;
                est_valid_q <= 1'b1;
            end else if (est_valid_q) begin
                // Step by one per reference period: no abrupt jumps
                if (per_est_q < per_meas) begin
                    per_est_q <= per_est_q + `PER_ONE;
                end else if (per_est_q > per_meas) begin
                    per_est_q <= per_est_q - `PER_ONE;
                end
                locked_q <= (per_est_q == per_meas);
            end
        end else if (per_cnt_q != `PER_MAX) begin
            per_cnt_q <= per_cnt_q + `PER_ONE;
        end
    end

    // Phase accumulator: (multiplier+1) events per reference period
    assign step     = {1'b0, vco_multiplier_q} + 6'h01;
    assign acc_sum  = acc_q + {10'h000, step};
    assign vco_tick = pll_on & est_valid_q & (acc_sum >= per_est_q);

    always @* begin
        acc_d = acc_q;
        if (!pll_on || !est_valid_q) begin
            acc_d = `PER_ZERO;
        end else if (vco_tick) begin
            acc_d = acc_sum - per_est_q;
        end else begin
            acc_d = acc_sum;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= `PER_ZERO;
        end else begin
            acc_q <= acc_d;
        end
    end

    // CPU divider phase; cleared when the halving select is written
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= 1'b0;
        end else if (sys_wr) begin
            phase_q <= 1'b0;
        end else if (mc_tick) begin
            phase_q <= ~phase_q;
        end
    end

    // Every master tick, or every second one when halved
    assign cpu_tick = mc_tick & (~cpu_clock_halve_q | ~phase_q);

    // Next clock levels
    always @* begin
        // Direct mode copies the oscillator duty cycle
        if (direct) begin
            mc_level_d = oscillator_clock;
        end else begin
            mc_level_d = mc_tick;
        end
        // Halved clock is a square wave over two master periods
        if (cpu_clock_halve_q) begin
            cpu_level_d = mc_tick ? ~phase_q : phase_q;
        end else begin
            cpu_level_d = mc_level_d;
        end
    end

    // Registered clock outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            master_clock             <= 1'b0;
            master_clock_tick        <= 1'b0;
            cpu_clock                <= 1'b0;
            cpu_clock_tick           <= 1'b0;
            cpu_core_clk_en          <= 1'b0;
            external_bus_ctrl_clk_en <= 1'b0;
            peripheral_clock         <= 1'b0;
            peripheral_clock_tick    <= 1'b0;
        end else begin
            master_clock             <= mc_level_d;
            master_clock_tick        <= mc_tick;
            cpu_clock                <= cpu_level_d;
            cpu_clock_tick           <= cpu_tick;
            // Core and bus controller run on the CPU clock
            cpu_core_clk_en          <= cpu_tick;
            external_bus_ctrl_clk_en <= cpu_tick;
            // Peripherals always at CPU frequency
            peripheral_clock         <= cpu_level_d;
            peripheral_clock_tick    <= cpu_tick;
        end
    end

endmodule // master_clock_prescaler

// >>> master_clock_prescaler_defs.vh
`ifndef MASTER_CLOCK_PRESCALER_DEFS_VH
`define MASTER_CLOCK_PRESCALER_DEFS_VH

// Register byte offsets on the APB bus
`define OFS_CLOCK_GEN_CONFIG   12'h000
`define OFS_SYSTEM_CONFIG_1    12'h004
`define OFS_CLOCK_STATUS       12'h008

// Register index codes returned by the address decoder
`define IDX_CLOCK_GEN_CONFIG   2'h0
`define IDX_SYSTEM_CONFIG_1    2'h1
`define IDX_CLOCK_STATUS       2'h2
`define IDX_NONE               2'h3

// Field layout of clock_gen_config
`define OPS_LSB                0
`define OPS_MSB                3
`define IPS_LSB                4
`define IPS_MSB                5
`define MODE_LSB               6
`define MODE_MSB               7
`define MUL_LSB                8
`define MUL_MSB                12

// Field layout of system_config_1 and of the status word
`define HALVE_BIT              0
`define ST_PLL_BIT             0
`define ST_LOCK_BIT            1
`define ST_HALVE_BIT           2
`define ST_PER_LSB             16

// Reset values
`define OPS_RST                4'h0
`define IPS_RST                2'h0
`define MODE_RST               2'h0
`define MUL_RST                5'h00
`define HALVE_RST              1'b0

// Clock mode codes and limits
`define MODE_PLL               2'h3
`define OPS_RESERVED           4'hf
`define PER_MAX                16'hffff
`define PER_ZERO               16'h0000
`define PER_ONE                16'h0001
`define DIV_ZERO               4'h0
`define RDATA_ZERO             32'h0000_0000

`endif

// >>> tick_divider.v
`timescale 1ns/1ps
`include "master_clock_prescaler_defs.vh"

// Passes every (div+1)-th input tick; a clear restarts the count
module tick_divider (
    input  wire       pclk,
    input  wire       presetn,
    input  wire       clear,     // Restart the count from zero
    input  wire       tick_in,   // One-cycle input event
    input  wire [3:0] div,       // Divide factor minus one
    output wire       tick_out   // One-cycle output event
);

    reg  [3:0] cnt_q;   // Input ticks seen in this period
    reg  [3:0] cnt_d;
    wire       wrap;    // Last input tick of the period

    // Wrap on the last tick; a shrunk divisor wraps at once
    assign wrap     = tick_in & (cnt_q >= div);
    assign tick_out = wrap;

    // Next count
    always @* begin
        cnt_d = cnt_q;
        if (clear) begin
            cnt_d = `DIV_ZERO;
        end else if (wrap) begin
            cnt_d = `DIV_ZERO;
        end else if (tick_in) begin
            cnt_d = cnt_q + 4'h1;
        end
    end

    // Count register
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= `DIV_ZERO;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule // tick_divider

// >>> master_clock_prescaler_properties.sv
`timescale 1ns/1ps
`include "master_clock_prescaler_defs.vh"

module master_clock_prescaler_properties (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        oscillator_clock,
    input wire        master_clock,
    input wire        master_clock_tick,
    input wire        cpu_clock,
    input wire        cpu_clock_tick,
    input wire        cpu_core_clk_en,
    input wire        external_bus_ctrl_clk_en,
    input wire        peripheral_clock,
    input wire        peripheral_clock_tick
);
    reg  [12:0] cfg_q;   // Shadow of the clock configuration word
    reg  [1:0]  dir_q;   // Direct-mode history, two cycles deep
    wire        mapped;  // Access hits one of the three registers
    wire        wr_cfg;  // Write to the clock configuration word
    wire        direct;  // Bypass with both prescalers at zero
    wire        dir_ok;  // Direct mode settled for a while

    assign mapped = paddr == `OFS_CLOCK_GEN_CONFIG ||
                    paddr == `OFS_SYSTEM_CONFIG_1 ||
                    paddr == `OFS_CLOCK_STATUS;
    assign wr_cfg = psel && penable && pwrite &&
                    paddr == `OFS_CLOCK_GEN_CONFIG;
    // Every mode but PLL is bypass, so mode 10 counts as direct too
    assign direct = cfg_q[7:6] != `MODE_PLL && cfg_q[5:0] == 6'h00;
    assign dir_ok = direct && dir_q == 2'b11;

    // Track the configuration; reserved output prescale keeps old value
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= 13'h0000;
            dir_q <= 2'b11;
        end else begin
            dir_q <= {dir_q[0], direct};
            if (wr_cfg) begin
                cfg_q[12:4] <= pwdata[12:4];
                if (pwdata[3:0] != `OPS_RESERVED) begin
                    cfg_q[3:0] <= pwdata[3:0];
                end
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_pready_zero_wait: assert property (pready == (psel && penable))
        else $error("pready not equal to access phase");
    chk_slverr_decode: assert property (psel && penable |-> pslverr == !mapped)
        else $error("pslverr does not match address decode");
    chk_unmapped_read: assert property (psel && penable && !pwrite && !mapped
        |-> prdata == `RDATA_ZERO) else $error("unmapped read not zero");
    chk_core_enable: assert property (cpu_core_clk_en == cpu_clock_tick)
        else $error("core enable differs from cpu tick");
    chk_bus_enable: assert property (external_bus_ctrl_clk_en == cpu_clock_tick)
        else $error("bus controller enable differs from cpu tick");
    chk_periph_same: assert property (peripheral_clock_tick == cpu_clock_tick
        && peripheral_clock == cpu_clock) else $error("peripheral clock differs");
    chk_cpu_on_master: assert property (cpu_clock_tick |-> master_clock_tick)
        else $error("cpu tick without master tick");
    chk_direct_follow: assert property (dir_ok && $past(presetn)
        |-> master_clock == $past(oscillator_clock))
        else $error("master clock not following oscillator");
    chk_direct_tick: assert property (dir_ok && $past(presetn)
        && $rose(oscillator_clock) |=> master_clock_tick || !direct)
        else $error("no master tick after oscillator rise");
    // Outside direct mode the master clock is a one-cycle pulse
    chk_master_pulse_form: assert property (!dir_q[0]
        |-> master_clock == master_clock_tick)
        else $error("master clock pulse differs from master tick");
    // Each CPU period starts with the CPU clock high
    chk_cpu_tick_high: assert property (cpu_clock_tick |-> cpu_clock)
        else $error("cpu clock low at cpu tick");
    // A master tick between CPU ticks drops the halved clock
    chk_cpu_half_low: assert property (master_clock_tick
        && !cpu_clock_tick |-> !cpu_clock)
        else $error("halved cpu clock high at mid-period tick");
endmodule // master_clock_prescaler_properties

// >>> tb_master_clock_prescaler.sv
`timescale 1ns/1ps
`include "master_clock_prescaler_defs.vh"

module tb_master_clock_prescaler;
    logic        pclk, presetn, psel, penable, pwrite, oscillator_clock;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, er, mc, mt, cc, ct, ce, be, pc, pt;
    int          err_total, n_checks, osc_half, osc_cnt, g, n;

    master_clock_prescaler u_master_clock_prescaler (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .oscillator_clock(oscillator_clock), .master_clock(mc),
        .master_clock_tick(mt), .cpu_clock(cc), .cpu_clock_tick(ct),
        .cpu_core_clk_en(ce), .external_bus_ctrl_clk_en(be),
        .peripheral_clock(pc), .peripheral_clock_tick(pt));

    // 50 MHz bus clock
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // Oscillator toggles every osc_half bus cycles
    always @(posedge pclk) begin
        if (osc_cnt >= osc_half - 1) begin
            osc_cnt <= 0;
            oscillator_clock <= ~oscillator_clock;
        end else begin
            osc_cnt <= osc_cnt + 1;
        end
    end

    task tally_and_finish;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] v);
        n_checks++;
        if (v !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, v);
        end
    endtask

    // One APB transfer, held until pready is sampled high
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            err_total++;
            tally_and_finish();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Bus cycles between two ticks of master (0), cpu (1) or peripheral (2)
    task gap(input int sel);
        int k, seen;
        logic t;
        k = 0;
        seen = 0;
        g = 0;
        while (seen < 3 && k < 4000) begin
            @(posedge pclk);
            #1;
            k++;
            g++;
            t = sel == 0 ? mt : (sel == 1 ? ct : pt);
            if (t === 1'b1) begin
                seen++;
                if (seen < 3) g = 0;
            end
        end
        if (k >= 4000) begin
            err_total++;
            tally_and_finish();
        end
    endtask

    initial begin
        {psel, penable, pwrite, oscillator_clock} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        err_total = 0;
        n_checks = 0;
        osc_half = 2;
        osc_cnt = 0;
        presetn = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(`OFS_CLOCK_GEN_CONFIG, 1'b0, 0);
        chk("cfg reset", 32'h0000_0000, rd);
        apb(`OFS_SYSTEM_CONFIG_1, 1'b0, 0);
        chk("sys reset", 32'h0000_0000, rd);
        gap(0);
        chk("direct gap", 4, g);
        apb(`OFS_CLOCK_GEN_CONFIG, 1'b1, 32'h0000_0012);
        apb(`OFS_CLOCK_GEN_CONFIG, 1'b0, 0);
        chk("cfg readback", 32'h0000_0012, rd);
        gap(0);
        chk("bypass gap", 24, g);
        gap(1);
        chk("cpu gap full", 24, g);
        apb(`OFS_CLOCK_GEN_CONFIG, 1'b1, 32'h0000_003f);
        apb(`OFS_CLOCK_GEN_CONFIG, 1'b0, 0);
        chk("ops reserved", 32'h0000_0032, rd);
        apb(`OFS_CLOCK_GEN_CONFIG, 1'b1, 32'h0000_003e);
        gap(0);
        chk("slowest gap", 240, g);
        apb(`OFS_SYSTEM_CONFIG_1, 1'b1, 32'h0000_0001);
        apb(`OFS_SYSTEM_CONFIG_1, 1'b0, 0);
        chk("halve readback", 32'h0000_0001, rd);
        gap(1);
        chk("cpu gap halved", 480, g);
        gap(2);
        chk("periph gap", 480, g);
        apb(`OFS_CLOCK_STATUS, 1'b0, 0);
        chk("status halve", 32'h0000_0004, rd & 32'h0000_0007);
        apb(12'h00c, 1'b1, 32'h0000_0000);
        chk("unmapped wr err", 1, er);
        apb(12'h00c, 1'b0, 0);
        chk("unmapped rd err", 1, er);
        chk("unmapped rd data", 32'h0000_0000, rd);
        apb(`OFS_CLOCK_GEN_CONFIG, 1'b0, 0);
        chk("cfg kept", 32'h0000_003e, rd);
        apb(`OFS_SYSTEM_CONFIG_1, 1'b1, 32'h0000_0000);
        osc_half = 8;
        apb(`OFS_CLOCK_GEN_CONFIG, 1'b1, 32'h0000_0080);
        gap(0);
        chk("mode 10 bypass", 16, g);
        apb(`OFS_CLOCK_GEN_CONFIG, 1'b1, 32'h0000_03c0);
        repeat (400) @(posedge pclk);
        n = 0;
        repeat (160) begin
            @(posedge pclk);
            #1;
            if (mt === 1'b1) n++;
        end
        chk("pll tick count", 1, n >= 39 && n <= 41);
        apb(`OFS_CLOCK_STATUS, 1'b0, 0);
        chk("status pll lock", 32'h0010_0003, rd);
        tally_and_finish();
    end
endmodule // tb_master_clock_prescaler

bind master_clock_prescaler master_clock_prescaler_properties u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .oscillator_clock(oscillator_clock),
    .master_clock(master_clock), .master_clock_tick(master_clock_tick),
    .cpu_clock(cpu_clock), .cpu_clock_tick(cpu_clock_tick),
    .cpu_core_clk_en(cpu_core_clk_en),
    .external_bus_ctrl_clk_en(external_bus_ctrl_clk_en),
    .peripheral_clock(peripheral_clock),
    .peripheral_clock_tick(peripheral_clock_tick));
